// >>> hw/rtc_pkg.sv
// constants and types for the remote terminal controller
// assumes one 200 MHz clock and an APB master for software access
package rtc_pkg;
	// ****************
	// timing
	// ****************
	localparam longint CLK_HZ    = 200_000_000;
	localparam longint HOLD_MS   = 3000;
	localparam longint CFG_TO_MS = 75000;
	localparam longint COMM_MS   = 15000;
	localparam longint RXIDLE_MS = 1000;
	localparam longint FLASH_MS  = 500;
	localparam longint BEEP_MS   = 80;
	localparam longint BL_MS     = 30000;
	localparam longint HOLD_CYC   = HOLD_MS * (CLK_HZ / 1000);
	localparam longint CFG_TO_CYC = CFG_TO_MS * (CLK_HZ / 1000);
	localparam longint COMM_CYC   = COMM_MS * (CLK_HZ / 1000);
	localparam longint RXIDLE_CYC = RXIDLE_MS * (CLK_HZ / 1000);
	localparam longint FLASH_CYC  = FLASH_MS * (CLK_HZ / 1000);
	localparam longint BEEP_CYC   = BEEP_MS * (CLK_HZ / 1000);
	localparam longint BL_CYC     = BL_MS * (CLK_HZ / 1000);
	localparam int     TW         = 36;
	// ****************
	// address, contrast, identity
	// ****************
	localparam logic [7:0] ADDR_RST     = 8'hFF;
	localparam logic [7:0] ADDR_MIN     = 8'h01;
	localparam logic [7:0] ADDR_MAX     = 8'h1E;
	localparam logic [3:0] CONTR_RST    = 4'h8;
	localparam logic [7:0] FW_VERSION   = 8'h10; // arbitrary value
	// ****************
	// register map and fields
	// ****************
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_PANEL  = 4'h4;
	localparam logic [3:0] OFS_REPORT = 4'h8;
	localparam int PNL_ALARM = 0;
	localparam int PNL_PRE   = 1;
	localparam int PNL_FLT   = 2;
	localparam int PNL_ISO   = 3;
	localparam int PNL_EVT   = 4; // 3 bits: fire, fault, disable
	localparam int PNL_DEV   = 7;
	localparam logic [7:0] PANEL_RST  = 8'h00;
	localparam logic [2:0] REPORT_RST = 3'h7;
	// ****************
	// types
	// ****************
	typedef enum logic [1:0] {OP_PWRUP, OP_NORMAL, OP_FAULT} rtc_op_t;
	typedef enum logic [3:0] {
		SCR_PWRUP, SCR_CONFIG, SCR_NOCOMM, SCR_FAULT, SCR_SEEHOST,
		SCR_ALARM, SCR_PRE, SCR_SFLT, SCR_ISO, SCR_NORMAL
	} rtc_scr_t;
endpackage

// >>> hw/rtc_top.sv
// remote terminal controller: modes, timers, lamps, screen choice
// assumes synchronous button inputs and a decoder pulsing i_rx_valid
`timescale 1ns/10ps
module rtc_top #(
	parameter longint HOLD_CYC   = rtc_pkg::HOLD_CYC,
	parameter longint CFG_TO_CYC = rtc_pkg::CFG_TO_CYC,
	parameter longint COMM_CYC   = rtc_pkg::COMM_CYC,
	parameter longint RXIDLE_CYC = rtc_pkg::RXIDLE_CYC,
	// flash and backlight hold follow the hold time when it is scaled
	parameter longint FLASH_CYC  = HOLD_CYC * rtc_pkg::FLASH_CYC /
		rtc_pkg::HOLD_CYC,
	parameter longint BEEP_CYC   = rtc_pkg::BEEP_CYC,
	parameter longint BL_CYC     = HOLD_CYC * rtc_pkg::BL_CYC /
		rtc_pkg::HOLD_CYC
) (
	// clock and reset
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_RST_N,
	// apb slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [3:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// front panel controls
	input  wire logic        I_BTN_SETUP,
	input  wire logic        I_BTN_PREV,
	input  wire logic        I_BTN_NEXT,
	input  wire logic        I_BTN_SILENCE,
	input  wire logic        I_BTN_RESET,
	input  wire logic        I_KEY_EN,
	// health and link
	input  wire logic        I_HW_FAIL,
	input  wire logic        I_LCD_FAIL,
	input  wire logic        I_RX_VALID,
	// commands toward the host panel
	output logic             O_CMD_SILENCE,
	output logic             O_CMD_RESET,
	output logic             O_CMD_PREV,
	output logic             O_CMD_NEXT,
	// lamps, buzzer, display
	output logic             O_BUZZER,
	output logic             O_LED_SETUP,
	output logic             O_LINK_ACTIVITY_LED,
	output logic             O_LED_POWER,
	output logic             O_LED_HEALTHY,
	output logic [2:0]       O_LED_EVT,
	output logic             O_BACKLIGHT,
	output logic [3:0]       O_SCREEN,
	output logic [7:0]       O_ADDR,
	output logic [3:0]       O_CONTRAST
);
	localparam int TW = rtc_pkg::TW;

	typedef struct packed {
		rtc_pkg::rtc_op_t  op;
		logic              cfg;
		logic              held;
		logic [TW-1:0]     hold_cnt;
		logic [TW-1:0]     cfg_cnt;
		logic [TW-1:0]     comm_cnt;
		logic              rx_seen;
		logic [TW-1:0]     flash_cnt;
		logic              flash;
		logic [TW-1:0]     beep_cnt;
		logic [1:0]        beep_ph;
		logic [TW-1:0]     bl_cnt;
		logic [4:0]        btn_q;
		logic [7:0]        addr;
		logic [3:0]        contr;
		logic [7:0]        addr_sv;
		logic [3:0]        contr_sv;
		logic [7:0]        panel;
		logic [2:0]        report;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic [3:0]        cmd;
		logic              buzzer;
		logic              led_setup;
		logic              led_link;
		logic              led_pwr;
		logic              led_ok;
		logic [2:0]        led_evt;
		logic              bl;
		rtc_pkg::rtc_scr_t scr;
	} rtc_st_t;

	rtc_st_t s_r;
	rtc_st_t s_nxt;

	// address validity used by the state machine and assertions
	function automatic logic addr_ok(input logic [7:0] a);
		return a >= rtc_pkg::ADDR_MIN && a <= rtc_pkg::ADDR_MAX;
	endfunction

	// saturating counter step, shared by the hold and link timers
	function automatic logic [TW-1:0] cnt_up(input logic [TW-1:0] c,
		input longint lim);
		return (c < TW'(lim)) ? c + TW'(1) : TW'(lim);
	endfunction

	logic [4:0] btn;
	logic [4:0] press;
	logic       hold_hit;
	logic       cfg_to;
	logic       comm_lost;
	logic       rx_active;
	logic       fail;
	logic [2:0] evt;
	logic       apb_acc;
	logic       apb_done;

	// ****************
	// next-state logic
	// ****************
	always_comb begin
		s_nxt = s_r;
		btn = {I_BTN_SETUP, I_BTN_PREV, I_BTN_NEXT, I_BTN_SILENCE,
			I_BTN_RESET};
		press = btn & ~s_r.btn_q;
		s_nxt.btn_q = btn;
		apb_acc = I_PSEL & I_PENABLE & ~s_r.pready;
		apb_done = I_PSEL & I_PENABLE & I_PWRITE & s_r.pready;

		// setup hold timer, fires once per hold
		hold_hit = I_BTN_SETUP && !s_r.held &&
			s_r.hold_cnt == TW'(HOLD_CYC - 1);
		s_nxt.hold_cnt = I_BTN_SETUP ? cnt_up(s_r.hold_cnt, HOLD_CYC) : '0;
		s_nxt.held = I_BTN_SETUP & (s_r.held | hold_hit);

		// link timer, restarted by every valid host frame
		s_nxt.comm_cnt = I_RX_VALID ? '0 : cnt_up(s_r.comm_cnt, COMM_CYC);
		s_nxt.rx_seen = s_r.rx_seen | I_RX_VALID;
		comm_lost = s_r.rx_seen && s_r.comm_cnt == TW'(COMM_CYC);
		rx_active = s_r.rx_seen && s_r.comm_cnt < TW'(RXIDLE_CYC);

		// slow flash clock for lamps
		if (s_r.flash_cnt == TW'(FLASH_CYC - 1)) begin
			s_nxt.flash_cnt = '0;
			s_nxt.flash = ~s_r.flash;
		end else begin
			s_nxt.flash_cnt = s_r.flash_cnt + TW'(1);
		end

		// config mode entry, exit and timeout
		cfg_to = s_r.cfg && s_r.cfg_cnt == TW'(CFG_TO_CYC - 1);
		s_nxt.cfg_cnt = s_r.cfg ? s_r.cfg_cnt + TW'(1) : '0;
		if (hold_hit && !s_r.cfg) begin
			s_nxt.cfg = 1'b1;
			s_nxt.addr_sv = s_r.addr;
			s_nxt.contr_sv = s_r.contr;
		end else if (hold_hit) begin
			s_nxt.cfg = 1'b0;
		end else if (cfg_to) begin
			s_nxt.cfg = 1'b0; // revert to values held at entry
			s_nxt.addr = s_r.addr_sv;
			s_nxt.contr = s_r.contr_sv;
		end

		// adjustment in config mode, saturating
		if (s_r.cfg && !cfg_to) begin
			if (press[3])
				s_nxt.addr = addr_ok(s_r.addr) && s_r.addr > rtc_pkg::ADDR_MIN ?
					s_r.addr - 8'h01 : rtc_pkg::ADDR_MIN;
			else if (press[2])
				s_nxt.addr = addr_ok(s_r.addr) && s_r.addr < rtc_pkg::ADDR_MAX ?
					s_r.addr + 8'h01 : rtc_pkg::ADDR_MAX;
			if (press[1] && s_r.contr != 4'h0)
				s_nxt.contr = s_r.contr - 4'h1;
			else if (press[0] && s_r.contr != 4'hF)
				s_nxt.contr = s_r.contr + 4'h1;
		end

		// commands to the host, gated by access level
		s_nxt.cmd = '0;
		if (!s_r.cfg && s_r.op == rtc_pkg::OP_NORMAL) begin
			s_nxt.cmd[3] = press[1]; // silence works at either level
			s_nxt.cmd[2:0] = I_KEY_EN ? {press[0], press[3], press[2]} :
				3'h0;
		end

		// buzzer: double beep on entry, else one per press
		if (hold_hit && !s_r.cfg) begin
			s_nxt.beep_ph = 2'h3;
			s_nxt.beep_cnt = TW'(BEEP_CYC);
		end else if (|press) begin
			s_nxt.beep_ph = 2'h1;
			s_nxt.beep_cnt = TW'(BEEP_CYC);
		end else if (s_r.beep_ph != 2'h0) begin
			if (s_r.beep_cnt == TW'(1)) begin
				s_nxt.beep_ph = s_r.beep_ph - 2'h1;
				s_nxt.beep_cnt = TW'(BEEP_CYC);
			end else begin
				s_nxt.beep_cnt = s_r.beep_cnt - TW'(1);
			end
		end
		s_nxt.buzzer = s_nxt.beep_ph[0];

		// operating state machine
		fail = I_HW_FAIL | I_LCD_FAIL;
		case (s_r.op)
			rtc_pkg::OP_PWRUP: begin
				if (fail)
					s_nxt.op = rtc_pkg::OP_FAULT;
				else if (rx_active && addr_ok(s_r.addr))
					s_nxt.op = rtc_pkg::OP_NORMAL;
			end
			rtc_pkg::OP_NORMAL: begin
				if (fail || comm_lost)
					s_nxt.op = rtc_pkg::OP_FAULT;
			end
			rtc_pkg::OP_FAULT: begin
				if (!fail && rx_active && addr_ok(s_r.addr))
					s_nxt.op = rtc_pkg::OP_NORMAL;
			end
			default: s_nxt.op = rtc_pkg::OP_PWRUP;
		endcase

		// backlight hold after a key press
		s_nxt.bl_cnt = |press ? TW'(BL_CYC) :
			(s_r.bl_cnt != '0 ? s_r.bl_cnt - TW'(1) : '0);
		s_nxt.bl = s_r.panel[rtc_pkg::PNL_ALARM] | I_KEY_EN |
			(s_nxt.bl_cnt != '0);

		// lamps
		evt = s_r.panel[rtc_pkg::PNL_DEV] ?
			s_r.panel[rtc_pkg::PNL_EVT +: 3] : 3'h0;
		s_nxt.led_evt = evt;
		s_nxt.led_setup = s_nxt.cfg & s_r.flash;
		s_nxt.led_link = !s_nxt.cfg && rx_active && s_r.flash;
		s_nxt.led_pwr = s_nxt.op == rtc_pkg::OP_NORMAL;
		s_nxt.led_ok = s_nxt.op != rtc_pkg::OP_FAULT;

		// screen choice, highest status wins
		if (s_nxt.cfg)
			s_nxt.scr = rtc_pkg::SCR_CONFIG;
		else if (s_r.op == rtc_pkg::OP_PWRUP)
			s_nxt.scr = rtc_pkg::SCR_PWRUP;
		else if (comm_lost)
			s_nxt.scr = rtc_pkg::SCR_NOCOMM;
		else if (s_r.op == rtc_pkg::OP_FAULT)
			s_nxt.scr = rtc_pkg::SCR_FAULT;
		else if (|(evt & ~s_r.report))
			s_nxt.scr = rtc_pkg::SCR_SEEHOST;
		else if (s_r.panel[rtc_pkg::PNL_ALARM])
			s_nxt.scr = rtc_pkg::SCR_ALARM;
		else if (s_r.panel[rtc_pkg::PNL_PRE])
			s_nxt.scr = rtc_pkg::SCR_PRE;
		else if (s_r.panel[rtc_pkg::PNL_FLT] || evt[1])
			s_nxt.scr = rtc_pkg::SCR_SFLT;
		else if (s_r.panel[rtc_pkg::PNL_ISO] || evt[2])
			s_nxt.scr = rtc_pkg::SCR_ISO;
		else
			s_nxt.scr = rtc_pkg::SCR_NORMAL;

		// apb: answer one cycle into the access phase
		s_nxt.pready = apb_acc;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = '0;
		if (apb_acc) begin
			case (I_PADDR)
				rtc_pkg::OFS_STATUS: begin
					s_nxt.prdata = {1'b0, rtc_pkg::FW_VERSION, s_r.contr,
						s_r.addr, 3'h0, s_r.scr, I_KEY_EN, s_r.cfg, s_r.op};
				end
				rtc_pkg::OFS_PANEL: begin
					s_nxt.prdata = {24'h000000, s_r.panel};
				end
				rtc_pkg::OFS_REPORT: begin
					s_nxt.prdata = {29'h00000000, s_r.report};
				end
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		// writes land only at the edge that completes the transfer
		if (apb_done && I_PADDR == rtc_pkg::OFS_PANEL)
			s_nxt.panel = I_PWDATA[7:0];
		if (apb_done && I_PADDR == rtc_pkg::OFS_REPORT)
			s_nxt.report = I_PWDATA[2:0];
	end

	// ****************
	// state register
	// ****************
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			s_r <= '0; // clears every timer
			s_r.op <= rtc_pkg::OP_PWRUP;
			s_r.addr <= rtc_pkg::ADDR_RST;
			s_r.addr_sv <= rtc_pkg::ADDR_RST;
			s_r.contr <= rtc_pkg::CONTR_RST;
			s_r.contr_sv <= rtc_pkg::CONTR_RST;
			s_r.panel <= rtc_pkg::PANEL_RST;
			s_r.report <= rtc_pkg::REPORT_RST;
			s_r.led_ok <= 1'b1;
			s_r.scr <= rtc_pkg::SCR_PWRUP;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign O_PRDATA = s_r.prdata;
	assign O_PREADY = s_r.pready;
	assign O_PSLVERR = s_r.pslverr;
	assign {O_CMD_SILENCE, O_CMD_RESET, O_CMD_PREV, O_CMD_NEXT} = s_r.cmd;
	assign O_BUZZER = s_r.buzzer;
	assign O_LED_SETUP = s_r.led_setup;
	assign O_LINK_ACTIVITY_LED = s_r.led_link;
	assign O_LED_POWER = s_r.led_pwr;
	assign O_LED_HEALTHY = s_r.led_ok;
	assign O_LED_EVT = s_r.led_evt;
	assign O_BACKLIGHT = s_r.bl;
	assign O_SCREEN = s_r.scr;
	assign O_ADDR = s_r.addr;
	assign O_CONTRAST = s_r.contr;

	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	a_cfg_entry_hold: assert property (
		$rose(s_r.cfg) |-> $past(s_r.hold_cnt) == TW'(HOLD_CYC - 1)
	) else $error("config entered without full hold");
	a_entry_double_beep: assert property (
		$rose(s_r.cfg) |-> s_r.beep_ph == 2'h3 && O_BUZZER
	) else $error("no double beep on entry");
	a_addr_range_kept: assert property (
		addr_ok(s_r.addr) && !cfg_to |=> addr_ok(s_r.addr)
	) else $error("address left valid range");
	a_low_access_gate: assert property (
		!$past(I_KEY_EN) |-> O_CMD_RESET == 1'b0 && O_CMD_NEXT == 1'b0 &&
			O_CMD_PREV == 1'b0
	) else $error("control acted at low access level");
	a_cfg_timeout_rev: assert property (
		cfg_to |=> !s_r.cfg && s_r.addr == $past(s_r.addr_sv)
	) else $error("timeout did not restore state");
	a_fault_on_fail: assert property (
		s_r.op == rtc_pkg::OP_NORMAL && I_HW_FAIL |=>
			s_r.op == rtc_pkg::OP_FAULT && !O_LED_HEALTHY
	) else $error("hardware fail missed");
	a_nocomm_screen: assert property (
		comm_lost && !s_r.cfg && s_r.op != rtc_pkg::OP_PWRUP |=>
			O_SCREEN == rtc_pkg::SCR_NOCOMM
	) else $error("no-comms screen missing");
	a_alarm_priority: assert property (
		s_r.op == rtc_pkg::OP_NORMAL && !s_r.cfg && !comm_lost &&
		s_r.panel[rtc_pkg::PNL_ALARM] && evt == 3'h0 |=>
			O_SCREEN == rtc_pkg::SCR_ALARM
	) else $error("alarm not shown first");
	a_link_led_idle: assert property (
		!rx_active |=> !O_LINK_ACTIVITY_LED
	) else $error("link lamp flashing without frames");
	a_apb_answer: assert property (
		I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY
	) else $error("apb access not answered");

	c_cfg_enter: cover property ($rose(s_r.cfg));
	c_cfg_timeout: cover property (cfg_to);
	c_go_normal: cover property ($rose(s_r.op == rtc_pkg::OP_NORMAL));
	c_see_host: cover property (O_SCREEN == rtc_pkg::SCR_SEEHOST);
endmodule

// >>> bench/rtc_host_model.sv
// host panel model: paces status frames, counts terminal commands
// assumes the terminal clock; a frame is a one-cycle valid pulse
`timescale 1ns/10ps
module rtc_host_model #(
	parameter int GAP = 10
) (
	// clock, reset, frame enable
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_run,
	// commands: silence, reset, prev, next
	input  wire logic [3:0]      i_cmd,
	// frame strobe and command tallies
	output logic                 o_rx_valid,
	output logic [3:0][7:0]      o_cnt
);
	int gap_q;
	// ****************
	// frames and commands
	// ****************
	// gap stays well under the idle limits so the link never looks lost while i_run is high
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_run) begin
			gap_q <= 0;
			o_rx_valid <= 1'b0;
		end else begin
			gap_q <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
			o_rx_valid <= (gap_q == GAP - 1);
		end
		for (int k = 0; k < 4; k++) begin
			if (!i_rst_n)
				o_cnt[k] <= 8'h00;
			else if (i_cmd[k])
				o_cnt[k] <= o_cnt[k] + 8'h01;
		end
	end
endmodule

// >>> bench/tb.sv
// testbench for the terminal controller: apb, buttons, host frames
// assumes shortened timer parameters and the host model beside it
`timescale 1ns/10ps
module tb;
	logic        clk, rst_n, psel, pen, pwr, key, run;
	logic [3:0]  paddr;
	logic [31:0] pwd, prd, rd;
	logic        prdy, perr, err, bz, lsu, llk, lpw, lhl, bl;
	logic [4:0]  btn;
	logic [1:0]  fl;
	logic [3:0]  cmd, scr, con;
	logic [2:0]  evt;
	logic [7:0]  adr;
	logic [3:0][7:0] cnt;
	logic        rxv;
	int bad_count, num_checks, cyc, rises, su_hi, lk_hi, b0, b1;
	logic        bz_q;
	logic [7:0] pv [5] = '{8'h03, 8'h06, 8'h04, 8'h08, 8'h00};
	logic [3:0] sv [5] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9};

	rtc_top #(.HOLD_CYC(20), .CFG_TO_CYC(200), .COMM_CYC(100),
		.RXIDLE_CYC(30), .BEEP_CYC(3)) dut_u (
		.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
		.O_PSLVERR(perr), .I_BTN_SETUP(btn[0]), .I_BTN_PREV(btn[1]),
		.I_BTN_NEXT(btn[2]), .I_BTN_SILENCE(btn[3]),
		.I_BTN_RESET(btn[4]), .I_KEY_EN(key), .I_HW_FAIL(fl[0]),
		.I_LCD_FAIL(fl[1]), .I_RX_VALID(rxv), .O_CMD_SILENCE(cmd[0]),
		.O_CMD_RESET(cmd[1]), .O_CMD_PREV(cmd[2]), .O_CMD_NEXT(cmd[3]),
		.O_BUZZER(bz), .O_LED_SETUP(lsu), .O_LINK_ACTIVITY_LED(llk),
		.O_LED_POWER(lpw), .O_LED_HEALTHY(lhl), .O_LED_EVT(evt),
		.O_BACKLIGHT(bl), .O_SCREEN(scr), .O_ADDR(adr),
		.O_CONTRAST(con));
	rtc_host_model host_u (.i_clk(clk), .i_rst_n(rst_n),
		.i_run(run), .i_cmd(cmd), .o_rx_valid(rxv), .o_cnt(cnt));

	// ****************
	// clock, monitors, timeout
	// ****************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// edge and high-time tallies so flashing needs no exact phase
	always @(posedge clk) begin
		cyc++;
		rises += (bz === 1'b1 && bz_q === 1'b0);
		bz_q <= bz;
		su_hi += (lsu === 1'b1);
		lk_hi += (llk === 1'b1);
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end

	// ****************
	// tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		chk("pready", prdy, 1'b1);
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic press(input int b, input int hold);
		@(posedge clk);
		btn[b] <= 1'b1;
		repeat (hold) @(posedge clk);
		btn[b] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic wscr(input logic [3:0] e, input int lim);
		int n;
		for (n = 0; n < lim && scr !== e; n++)
			@(posedge clk);
		chk("screen", scr, e);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		{rst_n, psel, pen, pwr, key, run} = 6'h00;
		{paddr, pwd, btn, fl} = '0;
		{bad_count, num_checks, cyc, rises, su_hi, lk_hi} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("addr", adr, 8'hFF);
		chk("screen", scr, 4'h0);
		chk("healthy", lhl, 1'b1);
		chk("contrast", con, 4'h8);
		apb(1'b0, 4'h8, '0);
		chk("report", rd, 32'h7);
		apb(1'b0, 4'hC, '0);
		chk("slverr", err, 1'b1);
		run <= 1'b1;
		key <= 1'b1;
		repeat (40) @(posedge clk);
		chk("power", lpw, 1'b0);
		press(0, 15);
		chk("screen", scr, 4'h0);
		b1 = rises;
		press(0, 25);
		chk("screen", scr, 4'h1);
		b0 = su_hi;
		repeat (20) @(posedge clk);
		chk("beeps", rises - b1, 32'h3);
		chk("setup lamp", su_hi > b0, 1'b1);
		b0 = rises;
		press(2, 2);
		chk("addr", adr, 8'h1E);
		chk("beep", rises > b0, 1'b1);
		press(2, 2);
		chk("addr", adr, 8'h1E);
		press(1, 2);
		chk("addr", adr, 8'h1D);
		press(3, 2);
		chk("contrast", con, 4'h7);
		press(4, 2);
		chk("contrast", con, 4'h8);
		press(0, 25);
		wscr(4'h9, 60);
		chk("power", lpw, 1'b1);
		apb(1'b0, 4'h0, '0);
		chk("status", rd, {1'b0, rtc_pkg::FW_VERSION, 4'h8, 8'h1D,
			3'h0, 4'h9, 1'b1, 1'b0, 2'h1});
		b0 = lk_hi;
		repeat (20) @(posedge clk);
		chk("link lamp", lk_hi > b0, 1'b1);
		key <= 1'b0;
		b0 = cnt[1];
		press(4, 2);
		chk("cmd reset", cnt[1], b0[7:0]);
		chk("backlight", bl, 1'b1);
		b0 = cnt[2];
		press(1, 2);
		chk("cmd prev", cnt[2], b0[7:0]);
		b0 = cnt[0];
		press(3, 2);
		chk("cmd silence", cnt[0], b0[7:0] + 8'h01);
		key <= 1'b1;
		b0 = cnt[1];
		press(4, 2);
		chk("cmd reset", cnt[1], b0[7:0] + 8'h01);
		chk("backlight", bl, 1'b1);
		b0 = cnt[2];
		press(1, 2);
		chk("cmd prev", cnt[2], b0[7:0] + 8'h01);
		b0 = cnt[3];
		press(2, 2);
		chk("cmd next", cnt[3], b0[7:0] + 8'h01);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 4'h4, {24'h0, pv[i]});
			wscr(sv[i], 10);
		end
		apb(1'b1, 4'h8, 32'h0);
		apb(1'b1, 4'h4, 32'h90);
		wscr(4'h4, 10);
		chk("event lamps", evt, 3'h1);
		apb(1'b1, 4'h4, 32'h10);
		repeat (4) @(posedge clk);
		chk("event lamps", evt, 3'h0);
		apb(1'b1, 4'h8, 32'h7);
		apb(1'b1, 4'h4, 32'h0);
		press(0, 25);
		chk("screen", scr, 4'h1);
		press(1, 2);
		chk("addr", adr, 8'h1C);
		wscr(4'h9, 260);
		chk("addr", adr, 8'h1D);
		for (int i = 0; i < 2; i++) begin
			fl <= 2'(i + 1);
			wscr(4'h3, 20);
			chk("healthy", lhl, 1'b0);
			fl <= 2'h0;
			wscr(4'h9, 40);
		end
		run <= 1'b0;
		wscr(4'h2, 150);
		chk("healthy", lhl, 1'b0);
		b0 = lk_hi;
		repeat (20) @(posedge clk);
		chk("link lamp", lk_hi, b0);
		// mid-run reset must bring back the power-up picture
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("addr", adr, 8'hFF);
		chk("screen", scr, 4'h0);
		chk("healthy", lhl, 1'b1);
		results();
	end
endmodule
